//--- src/scpi_command_parser_status.sv
// Command parser and status system of a dual-output instrument.
// Assumes a byte stream from the remote interface on sys_clk and
// an AXI4-Lite master for the register view.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "scpi_map.svh"
module scpi_command_parser_status
  import scpi_pkg::*;
#(
  parameter int KW_LEN = `KW_MAX
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rx_byte_t rxIn,
  input wire logic rxValid,
  output logic rxReady,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  input wire logic [7:0] isumSet1,
  input wire logic [7:0] isumSet2,
  input wire logic pendingOps,
  input wire logic serialPoll,
  input wire logic powerOn,
  output logic srq,
  output logic cmdError
);
  localparam int KB = 8 * KW_LEN;

  // ----------------------------------------------------------------
  // Keyword matching helpers
  // ----------------------------------------------------------------
  // Whole long form or exact short form only
  function automatic logic kwIs(input logic [KB-1:0] b,
    input logic [3:0] n, input logic [KB-1:0] s,
    input int lLen, input int sLen);
    logic ok;
    ok = (int'(n) == lLen) || (int'(n) == sLen);
    for (int i = 0; i < KW_LEN; i++)
    begin
      if (i < int'(n) && i < lLen)
      begin
        if (b[8*i +: 8] != s[8*(lLen-1-i) +: 8])
          ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic tk_t treeKind(input logic [2:0] d,
    input logic [KB-1:0] b, input logic [3:0] n,
    input logic hasN, input logic [3:0] num);
    tk_t k;
    k = TK_NONE;
    unique case (d)
      3'd0: if (kwIs(b, n, KB'("STATUS"), 6, 4) && !hasN)
        k = TK_NODE;
      3'd1: if (kwIs(b, n, KB'("QUESTIONABLE"), 12, 4) && !hasN)
        k = TK_NODE;
      3'd2: if (kwIs(b, n, KB'("INSTRUMENT"), 10, 4) && !hasN)
        k = TK_NODE;
      3'd3: if (kwIs(b, n, KB'("ISUMMARY"), 8, 4) && hasN &&
        (num == 4'd1 || num == 4'd2))
        k = TK_NODE;
      3'd4:
      begin
        if (kwIs(b, n, KB'("ENABLE"), 6, 4) && !hasN)
          k = TK_EN;
        else if (kwIs(b, n, KB'("EVENT"), 5, 4) && !hasN)
          k = TK_EV;
      end
      default: k = TK_NONE;
    endcase
    return k;
  endfunction

  // Common command names are three letters after the asterisk
  function automatic cmd_t commonCode(input logic [KB-1:0] b,
    input logic [3:0] n);
    logic [23:0] w;
    cmd_t c;
    w = {b[7:0], b[15:8], b[23:16]};
    c = CC_NONE;
    if (n == 4'd3)
    begin
      unique case (w)
        "CLS": c = CC_CLS;
        "ESE": c = CC_ESE;
        "ESR": c = CC_ESR;
        "OPC": c = CC_OPC;
        "PSC": c = CC_PSC;
        "SRE": c = CC_SRE;
        "STB": c = CC_STB;
        "WAI": c = CC_WAI;
        default: c = CC_NONE;
      endcase
    end
    return c;
  endfunction

  // Saturating scale by a small power of ten
  function automatic logic [7:0] scaleNum(input logic [16:0] v,
    input logic neg, input logic [3:0] e);
    logic [19:0] a;
    a = {3'b000, v};
    for (int i = 0; i < 3; i++)
    begin
      if (i < int'(e))
        a = neg ? a / 20'd10 : (a < 20'd65536 ? a * 20'd10 : a);
    end
    if (e > 4'd3)
      a = neg ? 20'd0 : 20'hfffff;
    return (a > 20'd255) ? `M_MAX : a[7:0];
  endfunction

  // Decimal text of an 8-bit value, LF appended
  function automatic resp_t decResp(input logic [7:0] v);
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] o;
    resp_t r;
    h = v / 8'd100;
    t = (v / 8'd10) % 8'd10;
    o = v % 8'd10;
    r.len = 3'd2;
    r.bytes = {16'h0000, `C_LF, 8'h30 + o};
    if (h != 8'd0)
    begin
      r.len = 3'd4;
      r.bytes = {`C_LF, 8'h30 + o, 8'h30 + t, 8'h30 + h};
    end
    else if (t != 8'd0)
    begin
      r.len = 3'd3;
      r.bytes = {8'h00, `C_LF, 8'h30 + o, 8'h30 + t};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pstate_t state;
  cmd_t cmd;
  logic [KB-1:0] kwBuf;
  logic [3:0] kwLen;
  logic isCommon, hasNum, query, endTerm, pendTerm;
  logic [3:0] keyNum;
  logic [2:0] depth;
  logic isumSel;
  logic [15:0] numVal;
  logic hasDig, fracMode, fracSeen, roundUp, unitMode;
  logic expMode, expNeg, negative, inStr, isStr, multi;
  logic [3:0] expVal;
  logic [7:0] quoteCh;
  resp_t resp;
  logic [2:0] respIdx;
  logic [7:0] esr, ese, sre, ev1, ev2, en1, en2, qinst;
  logic psc, trigMode, rqs, reqPrev;

  // ----------------------------------------------------------------
  // Byte classification
  // ----------------------------------------------------------------
  // EOI on an ordinary byte is replayed as LF one cycle later
  wire take = rxValid && rxReady;
  wire act = take || pendTerm;
  wire [7:0] ch = pendTerm ? `C_LF : rxIn.data;
  wire isTerm = pendTerm || ch == `C_LF ||
    (rxIn.eoi && (ch == `C_SEMI || ch == `C_CR));
  wire isLow = ch >= "a" && ch <= "z";
  wire isLet = isLow || (ch >= "A" && ch <= "Z");
  wire isDig = ch >= "0" && ch <= "9";
  wire [7:0] up = isLow ? ch - 8'h20 : ch;
  wire [3:0] dig = ch[3:0];
  wire isQuote = ch == `C_SQ || ch == `C_DQ;
  wire delim = isTerm || ch == `C_SEMI || ch == `C_COLON ||
    ch == `C_QM || ch == `C_SP;

  // ----------------------------------------------------------------
  // Keyword decode at a delimiter
  // ----------------------------------------------------------------
  wire tk_t tk = treeKind(depth, kwBuf, kwLen, hasNum, keyNum);
  wire cmd_t cc = commonCode(kwBuf, kwLen);
  wire cmd_t leaf = isCommon ? cc : tk == TK_EN ? CC_ISEN :
    (tk == TK_EV || (tk == TK_NODE && depth == 3'd3 &&
    ch != `C_COLON)) ? CC_ISEV : CC_NONE;
  wire descend = !isCommon && tk == TK_NODE && ch == `C_COLON;
  wire emptyKw = kwLen == 4'd0 && !isCommon;
  wire keyErr = (leaf == CC_NONE && !descend) ||
    (leaf != CC_NONE && ch == `C_COLON);

  // ----------------------------------------------------------------
  // Parameter value and command check
  // ----------------------------------------------------------------
  wire wOn = kwIs(kwBuf, kwLen, KB'("ON"), 2, 2);
  wire wOff = kwIs(kwBuf, kwLen, KB'("OFF"), 3, 3);
  wire wMin = kwIs(kwBuf, kwLen, KB'("MINIMUM"), 7, 3);
  wire wMax = kwIs(kwBuf, kwLen, KB'("MAXIMUM"), 7, 3);
  wire wDef = kwIs(kwBuf, kwLen, KB'("DEFAULT"), 7, 3);
  wire hasWord = kwLen != 4'd0;
  wire hasPar = hasWord || hasDig || isStr;
  wire [7:0] scaled = scaleNum({1'b0, numVal} + {16'h0000, roundUp},
    expNeg, expVal);
  wire [7:0] pVal = wOn ? 8'd1 : wMax ? `M_MAX :
    hasWord ? 8'd0 : scaled;
  wire parBad = isStr || multi || inStr ||
    (hasWord && !(wOn || wOff || wMin || wMax || wDef)) ||
    (negative && scaled != 8'd0);
  wire limQ = query && (wMin || wMax) && !hasDig;
  wire isMask = cmd == CC_ESE || cmd == CC_SRE || cmd == CC_ISEN;
  wire cmdBad = (hasPar && parBad && !limQ) ||
    (isMask && (query ? hasPar && !limQ : !hasPar)) ||
    (cmd == CC_PSC && (query ? hasPar : !hasPar || pVal > 8'd1)) ||
    ((cmd == CC_ESR || cmd == CC_STB || cmd == CC_ISEV) &&
    (!query || hasPar)) ||
    ((cmd == CC_CLS || cmd == CC_WAI) && (query || hasPar)) ||
    (cmd == CC_OPC && hasPar) || cmd == CC_NONE;
  wire inExec = state == ST_EXEC;
  wire doSet = inExec && !cmdBad && !query;
  wire doQry = inExec && !cmdBad && query;
  wire needWait = cmd == CC_OPC ||
    (cmd == CC_WAI && trigMode);

  // Query answer source
  wire [7:0] selEn = isumSel ? en2 : en1;
  wire [7:0] maskQ = wMin ? 8'd0 : wMax ? `M_MAX :
    cmd == CC_ESE ? ese : cmd == CC_SRE ? sre : selEn;
  wire [7:0] stb = {1'b0, rqs, |(esr & ese),
    state == ST_RESP, |qinst, 3'b000};
  wire [7:0] qVal = isMask ? maskQ : cmd == CC_PSC ? {7'd0, psc} :
    cmd == CC_ESR ? esr : cmd == CC_STB ? stb :
    isumSel ? ev2 : ev1;

  // ----------------------------------------------------------------
  // Parser sequencing
  // ----------------------------------------------------------------
  // Ready drops for a cycle after each byte; halves peak rate but
  // gives the cycle that replays an EOI as a terminator
  wire accepting = state == ST_KEY || state == ST_PARAM ||
    state == ST_SKIP;

  task automatic clearCmd();
    kwLen <= 4'd0;
    isCommon <= 1'b0;
    hasNum <= 1'b0;
    query <= 1'b0;
    numVal <= 16'd0;
    {hasDig, fracMode, fracSeen, roundUp, unitMode} <= 5'd0;
    {expMode, expNeg, negative, inStr, isStr, multi} <= 6'd0;
    expVal <= 4'd0;
  endtask

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ST_KEY;
      cmd <= CC_NONE;
      kwBuf <= '0;
      keyNum <= 4'd0;
      depth <= 3'd0;
      isumSel <= 1'b0;
      endTerm <= 1'b0;
      pendTerm <= 1'b0;
      quoteCh <= 8'h00;
      resp <= '0;
      respIdx <= 3'd0;
      rxReady <= 1'b0;
      txValid <= 1'b0;
      txData <= 8'h00;
      cmdError <= 1'b0;
      clearCmd();
    end
    else
    begin
      rxReady <= accepting && !take;
      pendTerm <= take && rxIn.eoi && !delim && ch != `C_CR;
      cmdError <= 1'b0;
      unique case (state)
        ST_KEY:
        if (act && delim && emptyKw)
        begin
          if (isTerm || ch == `C_COLON)
            depth <= 3'd0;
        end
        else if (act && delim && keyErr)
        begin
          cmdError <= 1'b1;
          state <= isTerm ? ST_KEY : ST_SKIP;
          if (isTerm)
            depth <= 3'd0;
          clearCmd();
        end
        else if (act && descend)
        begin
          depth <= depth + 3'd1;
          kwLen <= 4'd0;
          hasNum <= 1'b0; // Index digit ends with its node
          if (depth == 3'd3)
            isumSel <= keyNum == 4'd2;
        end
        else if (act && delim)
        begin
          cmd <= leaf;
          kwLen <= 4'd0;
          query <= ch == `C_QM;
          endTerm <= isTerm;
          if (!isCommon && tk == TK_NODE)
            isumSel <= keyNum == 4'd2;
          state <= (ch == `C_QM || ch == `C_SP) ? ST_PARAM : ST_EXEC;
        end
        else if (act && ch == `C_STAR && emptyKw)
          isCommon <= 1'b1;
        else if (act && isDig && kwLen != 4'd0)
        begin
          hasNum <= 1'b1;
          keyNum <= dig;
        end
        else if (act && isLet && !hasNum)
        begin
          if (kwLen < 4'(KW_LEN))
            kwBuf[8*kwLen +: 8] <= up;
          if (kwLen <= 4'(KW_LEN))
            kwLen <= kwLen + 4'd1;
        end
        else if (act && ch != `C_CR)
        begin
          cmdError <= 1'b1;
          state <= ST_SKIP;
          clearCmd();
        end

        ST_PARAM:
        if (act && inStr)
          inStr <= ch != quoteCh;
        else if (act && (isTerm || ch == `C_SEMI))
        begin
          endTerm <= isTerm;
          state <= ST_EXEC;
        end
        else if (act && isQuote)
        begin
          inStr <= 1'b1;
          isStr <= 1'b1;
          quoteCh <= ch;
        end
        else if (act && ch == `C_COMMA)
          multi <= 1'b1;
        else if (act && ch == `C_MINUS)
        begin
          if (expMode)
            expNeg <= 1'b1;
          else
            negative <= 1'b1;
        end
        else if (act && ch == `C_DOT)
          fracMode <= 1'b1;
        else if (act && isDig && expMode)
          expVal <= (expVal > 4'd9) ? expVal : 4'(expVal * 4'd10 + dig);
        else if (act && isDig && fracMode)
        begin
          hasDig <= 1'b1;
          fracSeen <= 1'b1;
          if (!fracSeen)
            roundUp <= dig >= 4'd5;
        end
        else if (act && isDig)
        begin
          hasDig <= 1'b1;
          numVal <= (numVal > 16'd6552) ? 16'hffff :
            16'(numVal * 16'd10 + {12'd0, dig});
        end
        else if (act && isLet && hasDig)
        begin
          if (up == "E" && !unitMode)
            expMode <= 1'b1;
          else
            unitMode <= 1'b1; // units V, A, SEC
        end
        else if (act && isLet && kwLen < 4'(KW_LEN))
        begin
          kwBuf[8*kwLen +: 8] <= up;
          kwLen <= kwLen + 4'd1;
        end

        ST_SKIP:
        if (act && isTerm)
        begin
          depth <= 3'd0;
          state <= ST_KEY;
          clearCmd();
        end

        ST_EXEC:
        begin
          if (endTerm)
            depth <= 3'd0;
          if (cmdBad)
          begin
            cmdError <= 1'b1;
            state <= ST_KEY;
            clearCmd();
          end
          else if (needWait)
            state <= ST_WAIT;
          else if (query)
          begin
            resp <= decResp(qVal);
            respIdx <= 3'd0;
            state <= ST_RESP;
          end
          else
          begin
            state <= ST_KEY;
            clearCmd();
          end
        end

        ST_WAIT:
        if (!pendingOps)
        begin
          if (query)
          begin
            resp <= decResp(8'd1);
            respIdx <= 3'd0;
            state <= ST_RESP;
          end
          else
          begin
            state <= ST_KEY;
            clearCmd();
          end
        end

        ST_RESP:
        if (!txValid || txReady)
        begin
          if (respIdx < resp.len)
          begin
            txData <= resp.bytes[8*respIdx +: 8];
            txValid <= 1'b1;
            respIdx <= respIdx + 3'd1;
          end
          else
          begin
            txValid <= 1'b0;
            state <= ST_KEY;
            clearCmd();
          end
        end

        default: state <= ST_KEY;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic [7:0] awAddr, wByte;
  logic awFull, wFull, wLane;
  wire wrGo = awFull && wFull && !s_axi_bvalid;
  wire wrHit = awAddr == `A_ESE || awAddr == `A_SRE ||
    awAddr == `A_ISEN1 || awAddr == `A_ISEN2 || awAddr == `A_CTRL;
  wire axWr = wrGo && wrHit && wLane;
  wire [7:0] rdAddr = s_axi_araddr;
  wire rdHit = rdAddr <= `A_CTRL && rdAddr[1:0] == 2'b00;
  wire [7:0] rdMux = rdAddr == `A_STB ? stb :
    rdAddr == `A_ESR ? esr : rdAddr == `A_ESE ? ese :
    rdAddr == `A_SRE ? sre : rdAddr == `A_ISEN1 ? en1 :
    rdAddr == `A_ISEN2 ? en2 : rdAddr == `A_ISEV1 ? ev1 :
    rdAddr == `A_ISEV2 ? ev2 : rdAddr == `A_QINST ? qinst :
    rdAddr == `A_CTRL ? {6'd0, psc, trigMode} : 8'h00;

  // Address and data taken in either order, one write at a time
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {s_axi_awready, s_axi_wready, s_axi_bvalid} <= 3'b000;
      {s_axi_arready, s_axi_rvalid, awFull, wFull, wLane} <= 5'd0;
      {s_axi_bresp, s_axi_rresp} <= 4'd0;
      {awAddr, wByte} <= 16'h0000;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      s_axi_awready <= !awFull && !s_axi_awready;
      s_axi_wready <= !wFull && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awFull <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wFull <= 1'b1;
        wByte <= s_axi_wdata[7:0];
        wLane <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wrGo)
      begin
        {awFull, wFull} <= 2'b00;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rdMux};
        s_axi_rresp <= rdHit ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status registers
  // ----------------------------------------------------------------
  wire cls = doSet && cmd == CC_CLS;
  wire clrEv = (doQry && cmd == CC_ISEV) || cls;
  wire pwrClr = powerOn && psc;
  wire opcDone = state == ST_WAIT && !pendingOps &&
    cmd == CC_OPC && !query;
  wire [7:0] esrSet = {2'b00, cmdError, 4'd0, opcDone};
  wire reqNow = |({stb[7], 1'b0, stb[5:0]} & sre);

  // Event latches: a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {esr, ev1, ev2, qinst} <= 32'h0000_0000;
      {ese, sre, en1, en2} <= {4{`R_MASK}};
      psc <= `R_PSC;
      {trigMode, rqs, reqPrev, srq} <= 4'd0;
    end
    else
    begin
      esr <= ((cls || (doQry && cmd == CC_ESR)) ? 8'h00 : esr) |
        esrSet;
      ev1 <= ((clrEv && !isumSel) || cls ? 8'h00 : ev1) | isumSet1;
      ev2 <= ((clrEv && isumSel) || cls ? 8'h00 : ev2) | isumSet2;
      qinst <= {5'd0, |(ev2 & en2), |(ev1 & en1), 1'b0};
      if (pwrClr || (doSet && cmd == CC_ESE))
        ese <= pwrClr ? 8'h00 : pVal;
      else if (axWr && awAddr == `A_ESE)
        ese <= wByte;
      if (pwrClr || (doSet && cmd == CC_SRE))
        sre <= pwrClr ? 8'h00 : pVal & 8'hbf;
      else if (axWr && awAddr == `A_SRE)
        sre <= wByte & 8'hbf;
      if (doSet && cmd == CC_ISEN && !isumSel)
        en1 <= pVal;
      else if (axWr && awAddr == `A_ISEN1)
        en1 <= wByte;
      if (doSet && cmd == CC_ISEN && isumSel)
        en2 <= pVal;
      else if (axWr && awAddr == `A_ISEN2)
        en2 <= wByte;
      if (doSet && cmd == CC_PSC)
        psc <= pVal[0];
      else if (axWr && awAddr == `A_CTRL)
        {psc, trigMode} <= {wByte[`B_PSC], wByte[`B_TRIG]};
      // Request bit: set on a new enabled reason, cleared by poll
      reqPrev <= reqNow;
      if (reqNow && !reqPrev)
        rqs <= 1'b1;
      else if (serialPoll || !reqNow || cls)
        rqs <= 1'b0;
      srq <= rqs;
    end
  end
endmodule
`default_nettype wire

//--- common/scpi_map.svh
// Constants for the command parser and status block: offsets,
// field positions, reset values and character codes.
// Assumes byte addressing on an AXI4-Lite bus with 8-bit registers.
`ifndef SCPI_MAP_SVH
`define SCPI_MAP_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define A_STB 8'h00
`define A_ESR 8'h04
`define A_ESE 8'h08
`define A_SRE 8'h0c
`define A_ISEN1 8'h10
`define A_ISEN2 8'h14
`define A_ISEV1 8'h18
`define A_ISEV2 8'h1c
`define A_QINST 8'h20
`define A_CTRL 8'h24
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define B_QUES 3
`define B_MAV 4
`define B_ESB 5
`define B_RQS 6
`define B_OPC 0
`define B_CME 5
`define B_TRIG 0
`define B_PSC 1
`define R_PSC 1'b1
`define R_MASK 8'h00
`define M_MAX 8'hff
`define KW_MAX 12
// ----------------------------------------------------------------
// Character codes
// ----------------------------------------------------------------
`define C_LF 8'h0a
`define C_CR 8'h0d
`define C_SP 8'h20
`define C_DQ 8'h22
`define C_SQ 8'h27
`define C_STAR 8'h2a
`define C_PLUS 8'h2b
`define C_COMMA 8'h2c
`define C_MINUS 8'h2d
`define C_DOT 8'h2e
`define C_COLON 8'h3a
`define C_SEMI 8'h3b
`define C_QM 8'h3f
`endif

//--- common/scpi_pkg.sv
// Types shared by the command parser and its bench.
// Assumes nothing of its surroundings.
package scpi_pkg;
  typedef enum logic [5:0]
  {
    ST_KEY = 6'b000001,
    ST_PARAM = 6'b000010,
    ST_SKIP = 6'b000100,
    ST_EXEC = 6'b001000,
    ST_WAIT = 6'b010000,
    ST_RESP = 6'b100000
  } pstate_t;
  typedef enum logic [3:0]
  {
    CC_NONE, CC_CLS, CC_ESE, CC_ESR, CC_OPC, CC_PSC,
    CC_SRE, CC_STB, CC_WAI, CC_ISEN, CC_ISEV
  } cmd_t;
  typedef enum logic [1:0] {TK_NONE, TK_NODE, TK_EN, TK_EV} tk_t;
  typedef struct packed
  {
    logic [7:0] data;
    logic eoi;
  } rx_byte_t;
  typedef struct packed
  {
    logic [2:0] len;
    logic [31:0] bytes;
  } resp_t;
endpackage

//--- tb/scpi_ctrl_model.sv
// Remote controller model: sends program messages, collects replies.
// Assumes the parser's rx/tx byte handshake on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module scpi_ctrl_model
  import scpi_pkg::*;
(
  input wire logic sys_clk,
  output rx_byte_t rxIn,
  output logic rxValid,
  input wire logic rxReady,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady
);
  string got = "";
  initial
  begin
    rxIn = '0;
    rxValid = 1'b0;
    txReady = 1'b1;
  end
  // Reply bytes, taken at once
  always @(posedge sys_clk)
    if (txValid === 1'b1)
      got = $sformatf("%s%c", got, txData);
  // Byte held until taken; callers end with LF
  task automatic send(input string s);
    foreach (s[i])
    begin
      rxIn <= '{s[i], 1'b0};
      rxValid <= 1'b1;
      do @(posedge sys_clk); while (rxReady !== 1'b1);
    end
    rxValid <= 1'b0;
    rxIn <= ~rxIn;  // Released bus shows no stale byte
  endtask
endmodule
`default_nettype wire

//--- tb/scpi_command_parser_status_props.sv
// Port checks for the command parser and status block.
// Bound to the parser top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module scpi_command_parser_status_props
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic rxValid,
  input wire logic rxReady,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic cmdError
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Answers stand until taken; also byte-wide read data, decimal replies, rx gap and one-cycle error pulse
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  AST_R_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready high");
  AST_R_BYTE: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 0) else $error("upper bits set");
  AST_TX_HOLD: assert property (txValid && !txReady
    |=> txValid && $stable(txData)) else $error("tx byte moved");
  AST_TX_DEC: assert property (txValid |-> txData == 8'h0a
    || (txData >= 8'h30 && txData <= 8'h39)) else $error("not decimal");
  AST_RX_GAP: assert property (rxValid && rxReady |=> !rxReady)
    else $error("rx gap missing");
  AST_ERR_ONE: assert property (cmdError |=> !cmdError)
    else $error("error pulse long");
  // Main scenarios
  cover property (cmdError);
  cover property (txValid && txData == 8'h0a);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind scpi_command_parser_status scpi_command_parser_status_props
  props_inst (.*);
`default_nettype wire

//--- tb/scpi_command_parser_status_test.sv
// Self-checking bench for the command parser and status block.
// Drives AXI4-Lite itself; the controller model drives the bytes.
`timescale 1ns/1ps
`default_nettype none
module scpi_command_parser_status_test;
  import scpi_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, powerOn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, txData;
  logic [7:0] isumSet1 = 8'h00, isumSet2 = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, pendingOps = 0;
  logic serialPoll = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, rxValid, rxReady, txValid;
  logic txReady, srq, cmdError;
  logic [1:0] s_axi_bresp, s_axi_rresp, rresp;
  rx_byte_t rxIn;
  int num_errors = 0, compares = 0, errSeen = 0;
  scpi_command_parser_status scpi_command_parser_status_inst (.*);
  scpi_ctrl_model scpi_ctrl_model_inst (.*);
  // Clock and rejected-command count
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (cmdError === 1'b1) errSeen++;
  task automatic test_done();
    $display("Checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, e, g);
    end
  endtask
  // Reply complete once the parser listens again
  task automatic query(input string c, input string e);
    scpi_ctrl_model_inst.got = "";
    scpi_ctrl_model_inst.send(c);
    do @(posedge sys_clk); while (rxReady !== 1'b1);
    compares++;
    if (scpi_ctrl_model_inst.got != e)
    begin
      num_errors++;
      $display("Error reply expected %s seen %s", e,
        scpi_ctrl_model_inst.got);
    end
  endtask
  // AXI write: address and data offered together, released when taken
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    chk("bresp", 0, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rresp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic t_regs();
    axr(8'h24);
    chk("ctrl", 32'h2, rd);
    axr(8'h40);
    chk("rresp", 32'h2, rresp);
    axw(8'h0c, 8'h30);
    query("*SRE?\n", "48\n");
    $display("t_regs done");
  endtask
  task automatic t_isum();
    query("stat:ques:inst:isum1:enab 5\n", "");
    isumSet1 <= 8'h04;
    isumSet2 <= 8'hff;
    @(posedge sys_clk);
    isumSet1 <= 8'h00;
    isumSet2 <= 8'h00;
    @(posedge sys_clk);
    axr(8'h20);
    chk("summary", 32'h2, rd);
    query("STATUS:QUESTIONABLE:INSTRUMENT:ISUMMARY1:ENABLE?\n",
      "5\n");
    query("*SRE 0;:STAT:QUES:INST:ISUM2:ENAB 1\n", "");
    axr(8'h14);
    chk("isum2 mask", 32'h1, rd);
    $display("t_isum done");
  endtask
  task automatic t_common();
    query("*ese 36\n", "");
    query("*OPC?\n", "1\n");
    query("*PSC 0;*PSC?\n", "0\n");
    powerOn <= 1'b1;
    @(posedge sys_clk);
    powerOn <= 1'b0;
    query("*ESE?\n", "36\n");
    pendingOps <= 1'b1;
    scpi_ctrl_model_inst.send("*OPC\n");
    axr(8'h04);
    chk("opc early", 0, rd);
    pendingOps <= 1'b0;
    query("*ESR?\n", "1\n");
    $display("t_common done");
  endtask
  task automatic t_err();
    query("STAT:QUE:INST:ISUM1:ENAB 7\n", "");
    chk("rejects", 32'h1, errSeen);
    axr(8'h10);
    chk("mask kept", 32'h5, rd);
    axr(8'h04);
    chk("esr error", 32'h20, rd & 32'h20);
    axw(8'h0c, 8'h20);
    query("*STB?\n", "104\n");
    chk("srq", 1, srq);
    query("*CLS\n", "");
    axr(8'h04);
    chk("esr clear", 32'h0, rd);
    $display("t_err done");
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_isum();
    t_common();
    t_err();
    test_done();
  end
  // Watchdog: the run needs a few thousand cycles at most
  initial
  begin
    #200us;
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
